// ### inc/wlp_if.sv
// Purpose: link between the watchdog/low-power device and its controller
// Assumes: both ends on ref_clk
// Notes: all signals are same-domain logic
`timescale 1ns/10ps
interface wlp_if;
    logic key_wr;
    logic [7:0] key_val;
    logic wd_disable;
    logic wd_int_en;
    logic [1:0] power_mode_select;
    logic [wlp_pkg::QUAL_WIDTH-1:0] qual_count;
    logic [wlp_pkg::PIN_COUNT-1:0] wake_pin_select;
    logic lp_enter;
    logic int_pending;
    logic watchdog_reset_out_n;
    logic watchdog_wake_pulse_n;
    logic halt_refused;
    wlp_pkg::wlp_state_e lp_state;
    logic [wlp_pkg::WD_WIDTH-1:0] wd_count;

    modport dev (
        input key_wr, key_val, wd_disable, wd_int_en, power_mode_select,
        input qual_count, wake_pin_select, lp_enter, int_pending,
        output watchdog_reset_out_n, watchdog_wake_pulse_n, halt_refused,
        output lp_state, wd_count
    );
    modport ctl (
        output key_wr, key_val, wd_disable, wd_int_en, power_mode_select,
        output qual_count, wake_pin_select, lp_enter, int_pending,
        input watchdog_reset_out_n, watchdog_wake_pulse_n, halt_refused,
        input lp_state, wd_count
    );
endinterface : wlp_if

// ### inc/wlp_pkg.sv
// Purpose: shared constants for the watchdog and low-power wake block
// Assumes: one clock, ref_clk at 200 MHz, is the oscillator clock
// Notes: register offsets belong to the controller end
package wlp_pkg;
    // watchdog
    localparam int WD_WIDTH = 8;
    localparam logic [7:0] WD_MAX = 8'hff;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam int PULSE_CYCLES = 512;
    localparam logic [9:0] PULSE_LAST = 10'h1ff;
    // low-power mode field codes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam int QUAL_WIDTH = 6;
    localparam int PIN_COUNT = 32;
    // controller register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam logic [7:0] OFS_WAKESEL = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_QUAL_LSB = 2;
    localparam int CTRL_WD_DIS = 8;
    localparam int CTRL_WD_INT = 9;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    // interrupt status bits
    localparam int EV_WD_WAKE = 0;
    localparam int EV_WD_RESET = 1;
    localparam int EV_HALT_REFUSED = 2;
    localparam int EV_LP_EXIT = 3;
    localparam int EV_COUNT = 4;
    // low-power states
    typedef enum logic [1:0] {
        LP_RUN = 2'b00,
        LP_IDLE = 2'b01,
        LP_STANDBY = 2'b10,
        LP_HALT = 2'b11
    } wlp_state_e;
endpackage : wlp_pkg

// ### rtl/wlp_ctl.sv
// Purpose: controller end: registers, key forwarding, wake interrupt
// Assumes: plain register port, read data one cycle after strobe
// Notes: status bits clear by writing one; set wins over clear
`timescale 1ns/10ps
module wlp_ctl (
    input wire logic ref_clk,
    input wire logic nrst,
    wlp_if.ctl lnk,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [9:0] ctrl_ff;
    logic [31:0] wakesel_ff;
    logic [wlp_pkg::EV_COUNT-1:0] stat_ff;
    logic [wlp_pkg::EV_COUNT-1:0] mask_ff;
    logic [wlp_pkg::EV_COUNT-1:0] ev;
    logic wake_n_d_ff;
    logic rst_n_d_ff;
    logic in_lp_d_ff;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_ff <= wlp_pkg::CTRL_RESET;
            wakesel_ff <= '0;
            mask_ff <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == wlp_pkg::OFS_CTRL)
                ctrl_ff <= reg_wdata[9:0];
            else if (reg_addr == wlp_pkg::OFS_WAKESEL)
                wakesel_ff <= reg_wdata;
            else if (reg_addr == wlp_pkg::OFS_INT_MASK)
                mask_ff <= reg_wdata[wlp_pkg::EV_COUNT-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lnk.key_wr <= 1'b0;
            lnk.key_val <= '0;
            lnk.lp_enter <= 1'b0;
        end
        else
        begin
            lnk.key_wr <= reg_wr && reg_addr == wlp_pkg::OFS_KEY;
            lnk.key_val <= reg_wdata[7:0];
            lnk.lp_enter <= reg_wr && reg_addr == wlp_pkg::OFS_CMD
                            && reg_wdata[0];
        end
    end

    assign lnk.power_mode_select = ctrl_ff[wlp_pkg::CTRL_MODE_LSB +: 2];
    assign lnk.qual_count =
        ctrl_ff[wlp_pkg::CTRL_QUAL_LSB +: wlp_pkg::QUAL_WIDTH];
    assign lnk.wd_disable = ctrl_ff[wlp_pkg::CTRL_WD_DIS];
    assign lnk.wd_int_en = ctrl_ff[wlp_pkg::CTRL_WD_INT];
    assign lnk.wake_pin_select = wakesel_ff;

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wake_n_d_ff <= 1'b1;
            rst_n_d_ff <= 1'b1;
            in_lp_d_ff <= 1'b0;
        end
        else
        begin
            wake_n_d_ff <= lnk.watchdog_wake_pulse_n;
            rst_n_d_ff <= lnk.watchdog_reset_out_n;
            in_lp_d_ff <= lnk.lp_state != wlp_pkg::LP_RUN;
        end
    end

    always_comb
    begin
        ev = '0;
        ev[wlp_pkg::EV_WD_WAKE] = wake_n_d_ff && !lnk.watchdog_wake_pulse_n;
        ev[wlp_pkg::EV_WD_RESET] = rst_n_d_ff && !lnk.watchdog_reset_out_n;
        ev[wlp_pkg::EV_HALT_REFUSED] = lnk.halt_refused;
        ev[wlp_pkg::EV_LP_EXIT] = in_lp_d_ff
                                  && lnk.lp_state == wlp_pkg::LP_RUN;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            stat_ff <= '0;
        else if (reg_wr && reg_addr == wlp_pkg::OFS_INT_STAT)
            stat_ff <= (stat_ff & ~reg_wdata[wlp_pkg::EV_COUNT-1:0]) | ev;
        else
            stat_ff <= stat_ff | ev;
    end

    assign irq = |(stat_ff & mask_ff);
    assign lnk.int_pending = irq;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= '0;
        else if (!reg_rd)
            reg_rdata <= '0;
        else if (reg_addr == wlp_pkg::OFS_CTRL)
            reg_rdata <= {22'h000000, ctrl_ff};
        else if (reg_addr == wlp_pkg::OFS_WAKESEL)
            reg_rdata <= wakesel_ff;
        else if (reg_addr == wlp_pkg::OFS_STATUS)
            reg_rdata <= {22'h000000, lnk.lp_state, lnk.wd_count};
        else if (reg_addr == wlp_pkg::OFS_INT_STAT)
            reg_rdata <= {28'h0000000, stat_ff};
        else if (reg_addr == wlp_pkg::OFS_INT_MASK)
            reg_rdata <= {28'h0000000, mask_ff};
        else
            reg_rdata <= '0;
    end
endmodule : wlp_ctl

// ### rtl/wlp_dev.sv
// Purpose: watchdog counter and low-power mode controller
// Assumes: ref_clk is the oscillator clock; pins arrive asynchronously
// Notes: clock enables drive external gating cells
// Function
// - counter maximum gives 512-cycle low pulse
// - key 0x55 then 0xAA clears counter
// - counter holds while limp clock runs
// - standby keeps watchdog; wake pulse ends standby
// - idle wake pulse interrupts through expander
// - halt expiry gives full device reset
// - mode field: 00 idle, 01 standby, 1X halt
// - standby: oscillator on, cpu/system clocks off
// - halt: oscillator, PLL and cpu/system clocks off
// - short wake assertion returns to mode
// - halt entered only with watchdog clock active
// - idle: controller idle, interrupt exits
// - software selects port-A wake pins
// - wake pins qualified for programmed cycles
// - output pins hold levels in low power
// - debug port keeps its clock
// - missing input clock selects limp clock
`timescale 1ns/10ps
module wlp_dev #(
    parameter int PIN_W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    wlp_if.dev lnk,
    input wire logic external_reset_pin_n,
    input wire logic [wlp_pkg::PIN_COUNT-1:0] wake_pins_n,
    input wire logic debugger_wake_n,
    input wire logic input_clock_lost,
    input wire logic watchdog_clock_active,
    input wire logic [PIN_W-1:0] core_pins,
    output logic [PIN_W-1:0] out_pins,
    output logic cpu_clock_en,
    output logic system_clock_en,
    output logic osc_pll_en,
    output logic limp_clock_sel,
    output logic debug_clock_en
);
    localparam int SW = wlp_pkg::PIN_COUNT + 4;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic [wlp_pkg::PIN_COUNT-1:0] pins_n_s;
    logic ext_rst_n_s;
    logic dbg_n_s;
    logic limp_s;
    logic watchdog_clock_ok_s;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_ff <= {SW{1'b1}};
            sync2_ff <= {SW{1'b1}};
        end
        else
        begin
            sync1_ff <= {external_reset_pin_n, debugger_wake_n,
                         ~input_clock_lost, watchdog_clock_active,
                         wake_pins_n};
            sync2_ff <= sync1_ff;
        end
    end

    assign pins_n_s = sync2_ff[wlp_pkg::PIN_COUNT-1:0];
    assign watchdog_clock_ok_s = sync2_ff[SW-4];
    assign limp_s = ~sync2_ff[SW-3];
    assign dbg_n_s = sync2_ff[SW-2];
    assign ext_rst_n_s = sync2_ff[SW-1];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic wlp_pkg::wlp_state_e mode_of(input logic [1:0] sel);
        if (sel[1])
            return wlp_pkg::LP_HALT;
        else if (sel == wlp_pkg::MODE_STANDBY)
            return wlp_pkg::LP_STANDBY;
        else
            return wlp_pkg::LP_IDLE;
    endfunction : mode_of

    // ------------------------------------------------------------
    // watchdog counter and key
    // ------------------------------------------------------------
    logic [wlp_pkg::WD_WIDTH-1:0] wd_cnt_ff;
    logic key_armed_ff;
    logic key_done;
    logic wd_step;
    logic wd_expire;
    logic [9:0] pulse_cnt_ff;
    logic pulse_on_ff;
    logic rst_out_n_ff;
    logic wake_n_ff;
    logic dev_reset;
    wlp_pkg::wlp_state_e state_ff;
    wlp_pkg::wlp_state_e nxt_state;

    assign dev_reset = !ext_rst_n_s || !rst_out_n_ff;
    assign key_done = lnk.key_wr && key_armed_ff
                      && lnk.key_val == wlp_pkg::KEY_SECOND;
    assign wd_step = !lnk.wd_disable && !limp_s && !pulse_on_ff;
    assign wd_expire = wd_step && wd_cnt_ff == wlp_pkg::WD_MAX;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            key_armed_ff <= 1'b0;
        else if (dev_reset)
            key_armed_ff <= 1'b0;
        else if (lnk.key_wr)
            key_armed_ff <= lnk.key_val == wlp_pkg::KEY_FIRST;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wd_cnt_ff <= '0;
        else if (dev_reset || key_done || wd_expire)
            wd_cnt_ff <= '0;
        else if (wd_step)
            wd_cnt_ff <= wd_cnt_ff + 8'h01;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pulse_on_ff <= 1'b0;
            pulse_cnt_ff <= '0;
        end
        else if (wd_expire)
        begin
            pulse_on_ff <= 1'b1;
            pulse_cnt_ff <= '0;
        end
        else if (pulse_on_ff)
        begin
            pulse_on_ff <= pulse_cnt_ff != wlp_pkg::PULSE_LAST;
            pulse_cnt_ff <= pulse_cnt_ff + 10'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_out_n_ff <= 1'b1;
            wake_n_ff <= 1'b1;
        end
        else if (wd_expire)
        begin
            rst_out_n_ff <= !(state_ff == wlp_pkg::LP_HALT
                              || !lnk.wd_int_en);
            wake_n_ff <= state_ff == wlp_pkg::LP_HALT || !lnk.wd_int_en;
        end
        else if (pulse_on_ff && pulse_cnt_ff == wlp_pkg::PULSE_LAST)
        begin
            rst_out_n_ff <= 1'b1;
            wake_n_ff <= 1'b1;
        end
    end

    assign lnk.watchdog_wake_pulse_n = wake_n_ff;
    assign lnk.watchdog_reset_out_n = rst_out_n_ff;
    assign lnk.wd_count = wd_cnt_ff;

    // ------------------------------------------------------------
    // wake qualification
    // ------------------------------------------------------------
    logic [wlp_pkg::QUAL_WIDTH-1:0] qual_cnt_ff;
    logic wake_hit;
    logic wake_ok;
    logic in_deep;

    assign wake_hit = |(~pins_n_s & lnk.wake_pin_select) || !dbg_n_s;
    assign in_deep = state_ff == wlp_pkg::LP_STANDBY
                     || state_ff == wlp_pkg::LP_HALT;
    assign wake_ok = in_deep && wake_hit && qual_cnt_ff == lnk.qual_count;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            qual_cnt_ff <= '0;
        else if (!in_deep || !wake_hit || wake_ok)
            qual_cnt_ff <= '0;
        else
            qual_cnt_ff <= qual_cnt_ff + 6'h01;
    end

    // ------------------------------------------------------------
    // low-power state machine
    // ------------------------------------------------------------
    logic halt_refuse;

    assign halt_refuse = state_ff == wlp_pkg::LP_RUN && lnk.lp_enter
                         && mode_of(lnk.power_mode_select) == wlp_pkg::LP_HALT
                         && !watchdog_clock_ok_s;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            wlp_pkg::LP_RUN:
                if (lnk.lp_enter && !halt_refuse)
                    nxt_state = mode_of(lnk.power_mode_select);
            wlp_pkg::LP_IDLE:
                if (lnk.int_pending)
                    nxt_state = wlp_pkg::LP_RUN;
            wlp_pkg::LP_STANDBY:
                if (wake_ok || !wake_n_ff)
                    nxt_state = wlp_pkg::LP_RUN;
            wlp_pkg::LP_HALT:
                if (wake_ok)
                    nxt_state = wlp_pkg::LP_RUN;
            default:
                nxt_state = wlp_pkg::LP_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            state_ff <= wlp_pkg::LP_RUN;
        else if (dev_reset)
            state_ff <= wlp_pkg::LP_RUN;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            lnk.halt_refused <= 1'b0;
        else
            lnk.halt_refused <= halt_refuse;
    end

    assign lnk.lp_state = state_ff;

    // ------------------------------------------------------------
    // clock gating and pins
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cpu_clock_en <= 1'b1;
            system_clock_en <= 1'b1;
            osc_pll_en <= 1'b1;
            limp_clock_sel <= 1'b0;
            debug_clock_en <= 1'b1;
        end
        else
        begin
            cpu_clock_en <= nxt_state == wlp_pkg::LP_RUN
                            || nxt_state == wlp_pkg::LP_IDLE;
            system_clock_en <= nxt_state == wlp_pkg::LP_RUN
                               || nxt_state == wlp_pkg::LP_IDLE;
            osc_pll_en <= nxt_state != wlp_pkg::LP_HALT;
            limp_clock_sel <= limp_s;
            debug_clock_en <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            out_pins <= '0;
        else if (state_ff == wlp_pkg::LP_RUN && !lnk.lp_enter)
            out_pins <= core_pins;
    end
endmodule : wlp_dev

// ### tb/tb_watchdog_low_power_wake.sv
// Purpose: self-checking bench for the watchdog and low-power wake pair
// Assumes: ref_clk 200 MHz, nrst async active low
// Notes: all pins are driven by the sequence
`timescale 1ns/10ps
module tb_watchdog_low_power_wake;
    logic ref_clk;
    logic nrst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic irq;
    logic [31:0] wake_pins_n;
    logic input_clock_lost;
    logic watchdog_clock_active;
    logic [7:0] core_pins;
    logic [7:0] out_pins;
    logic cpu_clock_en;
    logic system_clock_en;
    logic osc_pll_en;
    logic limp_clock_sel;
    logic debug_clock_en;
    logic ext_rst_n, dbg_n;
    logic psel;
    logic [31:0] d;
    logic [31:0] e;
    int bad_count;
    int comparisons;
    int cycles;
    wlp_if lnk_if ();
    wire logic pl = psel ? lnk_if.watchdog_reset_out_n :
        lnk_if.watchdog_wake_pulse_n;
    wlp_dev #(.PIN_W(8)) wlp_dev_inst (.ref_clk, .nrst, .lnk(lnk_if),
        .external_reset_pin_n(ext_rst_n), .wake_pins_n,
        .debugger_wake_n(dbg_n), .input_clock_lost, .watchdog_clock_active,
        .core_pins, .out_pins, .cpu_clock_en, .system_clock_en, .osc_pll_en,
        .limp_clock_sel, .debug_clock_en);
    wlp_ctl wlp_ctl_inst (.ref_clk, .nrst, .lnk(lnk_if), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    wlp_chk_sva chk_inst (.ref_clk, .nrst, .key_wr(lnk_if.key_wr),
        .key_val(lnk_if.key_val), .wd_int_en(lnk_if.wd_int_en),
        .power_mode_select(lnk_if.power_mode_select),
        .lp_enter(lnk_if.lp_enter), .int_pending(lnk_if.int_pending),
        .watchdog_reset_out_n(lnk_if.watchdog_reset_out_n),
        .watchdog_wake_pulse_n(lnk_if.watchdog_wake_pulse_n),
        .halt_refused(lnk_if.halt_refused), .lp_state(lnk_if.lp_state),
        .wd_count(lnk_if.wd_count));
    // ----------------------------------------
    // clock, timeout and access tasks
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task stop_test;
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task kick(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= wlp_pkg::OFS_KEY;
        reg_wdata <= {24'h0, a};
        @(posedge ref_clk);
        reg_wdata <= {24'h0, b};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : kick
    task state_is(input string nm, input logic [1:0] s);
        rd(wlp_pkg::OFS_STATUS);
        chk(nm, {30'h0, s}, {30'h0, d[9:8]});
    endtask : state_is
    task pin_low(input logic [31:0] p, input int n);
        @(posedge ref_clk);
        wake_pins_n <= p;
        repeat (n) @(posedge ref_clk);
        wake_pins_n <= 32'hffffffff;
    endtask : pin_low
    task pulse_len(input logic s, input string nm);
        int n;
        int k;
        n = 0;
        k = 0;
        psel = s;
        #1;
        while (pl !== 1'b0 && k < 600)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        while (pl === 1'b0 && n < 600)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(nm, 32'h200, n);
    endtask : pulse_len
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        nrst = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, input_clock_lost, psel} = '0;
        {ext_rst_n, dbg_n, wake_pins_n} = '1;
        watchdog_clock_active = 1'b1;
        core_pins = 8'ha5;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(wlp_pkg::OFS_STATUS);
        chk("cnt_rst", 32'h1, d[7:0] <= 8'h4);
        rd(wlp_pkg::OFS_CTRL);
        chk("ctrl_rst", {22'h0, wlp_pkg::CTRL_RESET}, d);
        rd(8'h1c);
        chk("unmapped", 32'h0, d);
        repeat (40) @(posedge ref_clk);
        kick(wlp_pkg::KEY_FIRST, wlp_pkg::KEY_SECOND);
        rd(wlp_pkg::OFS_STATUS);
        chk("kick", 32'h1, d[7:0] <= 8'h4);
        repeat (40) @(posedge ref_clk);
        kick(8'h12, wlp_pkg::KEY_SECOND);
        rd(wlp_pkg::OFS_STATUS);
        chk("bad_key", 32'h1, d[7:0] > 8'h20);
        input_clock_lost <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("limp_sel", 32'h1, limp_clock_sel);
        rd(wlp_pkg::OFS_STATUS);
        e = d;
        repeat (20) @(posedge ref_clk);
        rd(wlp_pkg::OFS_STATUS);
        chk("limp_hold", e, d);
        input_clock_lost <= 1'b0;
        pulse_len(1'b1, "rst_len");
        rd(wlp_pkg::OFS_INT_STAT);
        chk("ev_rst", 32'h1, d[wlp_pkg::EV_WD_RESET]);
        chk("irq_mask", 32'h0, irq);
        wr(wlp_pkg::OFS_INT_MASK, 32'h2);
        #1;
        chk("irq_on", 32'h1, irq);
        wr(wlp_pkg::OFS_INT_STAT, 32'hf);
        #1;
        chk("irq_off", 32'h0, irq);
        wr(wlp_pkg::OFS_CTRL, 32'h200);
        wr(wlp_pkg::OFS_INT_MASK, 32'h1);
        kick(wlp_pkg::KEY_FIRST, wlp_pkg::KEY_SECOND);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        core_pins <= 8'h5a;
        state_is("idle", 2'h1);
        chk("idle_cpu", 32'h1, cpu_clock_en);
        chk("pin_hold", 32'ha5, out_pins);
        pulse_len(1'b0, "wake_len");
        repeat (6) @(posedge ref_clk);
        state_is("idle_exit", 2'h0);
        wr(wlp_pkg::OFS_INT_STAT, 32'hf);
        wr(wlp_pkg::OFS_CTRL, 32'h111);
        wr(wlp_pkg::OFS_WAKESEL, 32'h8);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        state_is("standby", 2'h2);
        chk("sb_cpu", 32'h0, cpu_clock_en);
        chk("sb_sys", 32'h0, system_clock_en);
        chk("sb_osc", 32'h1, osc_pll_en);
        chk("sb_dbg", 32'h1, debug_clock_en);
        pin_low(32'hfffffffe, 20);
        pin_low(32'hfffffff7, 4);
        repeat (6) @(posedge ref_clk);
        state_is("sb_short", 2'h2);
        pin_low(32'hfffffff7, 12);
        repeat (4) @(posedge ref_clk);
        state_is("sb_exit", 2'h0);
        watchdog_clock_active <= 1'b0;
        wr(wlp_pkg::OFS_CTRL, 32'h103);
        repeat (3) @(posedge ref_clk);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        state_is("refused", 2'h0);
        rd(wlp_pkg::OFS_INT_STAT);
        chk("ev_refused", 32'h1, d[wlp_pkg::EV_HALT_REFUSED]);
        watchdog_clock_active <= 1'b1;
        wr(wlp_pkg::OFS_CTRL, 32'h202);
        repeat (3) @(posedge ref_clk);
        kick(wlp_pkg::KEY_FIRST, wlp_pkg::KEY_SECOND);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        state_is("halt", 2'h3);
        chk("halt_osc", 32'h0, osc_pll_en);
        chk("halt_cpu", 32'h0, cpu_clock_en);
        chk("halt_dbg", 32'h1, debug_clock_en);
        pulse_len(1'b1, "halt_len");
        state_is("halt_exit", 2'h0);
        wr(wlp_pkg::OFS_CTRL, 32'h201);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        pulse_len(1'b0, "sb_wd_len");
        state_is("sb_wd_exit", 2'h0);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        dbg_n <= 1'b0;
        state_is("sb_dbg", 2'h2);
        state_is("sb_dbg_exit", 2'h0);
        dbg_n <= 1'b1;
        wr(wlp_pkg::OFS_CTRL, 32'h002);
        wr(wlp_pkg::OFS_CMD, 32'h1);
        ext_rst_n <= 1'b0;
        state_is("xrs_halt", 2'h3);
        rd(wlp_pkg::OFS_STATUS);
        chk("xrs_exit", 32'h0, d[9:0]);
        stop_test();
    end
endmodule : tb_watchdog_low_power_wake

// ### tb/wlp_chk_sva.sv
// Purpose: interface checker for the watchdog and low-power wake pair
// Assumes: single ref_clk domain, nrst async active low
// Notes: instantiated beside the link interface in the bench
`timescale 1ns/10ps
module wlp_chk_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic key_wr,
    input wire logic [7:0] key_val,
    input wire logic wd_int_en,
    input wire logic [1:0] power_mode_select,
    input wire logic lp_enter,
    input wire logic int_pending,
    input wire logic watchdog_reset_out_n,
    input wire logic watchdog_wake_pulse_n,
    input wire logic halt_refused,
    input wire wlp_pkg::wlp_state_e lp_state,
    input wire logic [wlp_pkg::WD_WIDTH-1:0] wd_count
);
    logic [9:0] rlo_ff;
    logic [9:0] wlo_ff;
    // ----------------------------------------
    // low-cycle counters of the two pulses
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            rlo_ff <= 10'h0;
        else
            rlo_ff <= watchdog_reset_out_n ? 10'h0 : rlo_ff + 10'h1;
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            wlo_ff <= 10'h0;
        else
            wlo_ff <= watchdog_wake_pulse_n ? 10'h0 : wlo_ff + 10'h1;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    a_pulse_cause: assert property (
        ($fell(watchdog_reset_out_n) || $fell(watchdog_wake_pulse_n))
        |-> wd_count == 8'h0 && $past(wd_count) == 8'hff)
        else $error("pulse started without counter at maximum");
    a_reset_width: assert property (
        $rose(watchdog_reset_out_n) |-> rlo_ff == 10'h200)
        else $error("reset pulse width wrong");
    a_wake_width: assert property (
        $rose(watchdog_wake_pulse_n) |-> wlo_ff == 10'h200)
        else $error("wake pulse width wrong");
    a_key_clear: assert property (
        key_wr && key_val == 8'h55 ##1 key_wr && key_val == 8'haa
        |=> wd_count == 8'h0)
        else $error("key sequence did not clear counter");
    a_pulse_freeze: assert property (
        (!watchdog_wake_pulse_n && $past(!watchdog_wake_pulse_n))
        |-> $stable(wd_count))
        else $error("counter moved during wake pulse");
    a_wake_kind: assert property (
        $fell(watchdog_wake_pulse_n)
        |-> $past(wd_int_en) && $past(lp_state) != wlp_pkg::LP_HALT)
        else $error("wake pulse where reset pulse due");
    a_mode_enter: assert property (
        lp_enter && lp_state == wlp_pkg::LP_RUN && !power_mode_select[1]
        |=> lp_state == ($past(power_mode_select[0]) ?
        wlp_pkg::LP_STANDBY : wlp_pkg::LP_IDLE))
        else $error("wrong low-power state entered");
    a_halt_gate: assert property (
        lp_enter && lp_state == wlp_pkg::LP_RUN && power_mode_select[1]
        |=> (lp_state == wlp_pkg::LP_HALT) != halt_refused)
        else $error("halt request neither entered nor refused");
    a_idle_hold: assert property (
        lp_state == wlp_pkg::LP_IDLE && !int_pending && wd_count != 8'hff
        |=> lp_state == wlp_pkg::LP_IDLE)
        else $error("idle left without interrupt");
    a_idle_exit: assert property (
        lp_state == wlp_pkg::LP_IDLE && int_pending
        |-> ##[1:4] lp_state == wlp_pkg::LP_RUN)
        else $error("idle not left on interrupt");
    a_halt_reset: assert property (
        lp_state == wlp_pkg::LP_HALT && !watchdog_reset_out_n
        |-> ##[0:4] lp_state == wlp_pkg::LP_RUN)
        else $error("halt not left on watchdog reset");
    c_idle_exit: cover property (lp_state == wlp_pkg::LP_IDLE ##1
        lp_state == wlp_pkg::LP_RUN);
    c_refused: cover property (halt_refused);
    c_reset_end: cover property ($rose(watchdog_reset_out_n));
endmodule : wlp_chk_sva
